// >>> logic/ppr_map.vh
// constants for the poll responder: command codes, answer bytes, counts
// assumes a byte-wide receive and transmit path outside this block
`ifndef PPR_MAP_VH
`define PPR_MAP_VH
// ==========================================================
// bus command codes
`define PPR_ADDR_POLL 8'h4F
`define PPR_CMD_LEGACY 8'h3F
`define PPR_CMD_POLL 8'h40
`define PPR_CMD_DOWNLOAD 8'h26
`define PPR_CMD_READ 8'h52
`define PPR_CMD_STATUS 8'h53
`define PPR_ADDR_DISK1 8'h31
// ==========================================================
// poll sub-commands
`define PPR_SUB_RESET 8'h4F
`define PPR_SUB_NULL 8'h4E
`define PPR_SUB_MAIN 8'h00
// ==========================================================
// answer bytes
`define PPR_ACK 8'h41
`define PPR_NAK 8'h4E
`define PPR_COMPLETE 8'h43
// ==========================================================
// counts
`define PPR_RETRY_SLOTS 5'd26
`define PPR_DESC_LEN 8'd12
`define PPR_POLL_LEN 8'd4
`define PPR_BLOCK_LEN 8'd128
`define PPR_IMG_DEPTH 512
`define PPR_IMG_BLOCKS 8'd4
`define PPR_STATUS_HOLD 4'd3
`define PPR_FIFO_DEPTH 8
`endif

// >>> logic/ppr_responder.v
// poll responder: decodes command frames, answers polls, serves handler
// assumes framed bytes arrive one per valid pulse; a byte sink drains tx
// How it works
// R1: legacy poll answers twelve-byte transfer descriptor
// R2: legacy poll answered once until power cycle
// R3: disk-one sector read after several status requests
// R4: poll decoded by command code alone
// R5: poll reset clears state, sends nothing
// R6: main poll answers at own retry count
// R7: poll answer: length low, high, id, version
// R8: reported handler length always even
// R9: sticky answered flag cleared by reset only
// R10: null poll clears retry counter silently
// R11: named poll matches name and unit
// R12: download block number returns 128 bytes
// R13: block beyond image gets negative acknowledge
// R14: records start with type then length
// R15: data records 00, 01, 0A with offset
// R16: relocation offsets relative to last data record
// R17: high-byte relocation entries are byte pairs
// R18: stream ends with 0B, start code, address
// R19: acknowledge valid command, refuse invalid; nak only for repeat legacy poll or block past image, else silent
// R20: end-around-carry checksum on frames
// R21: power-up clear; other commands restart count
`include "ppr_map.vh"

// ==========================================================
// small byte fifo
module ppr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_in, // system clock
  input wire nrst_in, // async reset, low
  input wire [WIDTH-1:0] wr_data_in, // fill data
  input wire wr_valid_in, // fill valid
  output wire wr_ready_out, // room left
  output wire [WIDTH-1:0] rd_data_out, // head data
  output wire rd_valid_out, // head valid
  input wire rd_ready_in // drain ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage
  reg [AW-1:0] wp_reg; // write pointer
  reg [AW-1:0] rp_reg; // read pointer
  reg [AW:0] cnt_reg; // fill level
  wire do_wr; // push this cycle
  wire do_rd; // pop this cycle
  assign wr_ready_out = (cnt_reg != DEPTH);
  assign rd_valid_out = (cnt_reg != 0);
  assign rd_data_out = mem_reg[rp_reg];
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_valid_out && rd_ready_in;
  // storage write, no reset needed for data
  always @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem_reg[wp_reg] <= wr_data_in;
    end
  end
  // pointers and level
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ==========================================================
// top: command interpreter
module ppr_responder (
  input wire sys_clk_in, // 50 MHz clock
  input wire nrst_in, // async reset, low
  input wire [7:0] rx_byte_in, // received byte
  input wire rx_valid_in, // received byte strobe
  input wire cmd_line_in, // command line, high while asserted
  input wire [7:0] dev_id_in, // own download identifier
  input wire [7:0] version_in, // version byte
  input wire [4:0] retry_slot_in, // own retry number 1..26
  input wire [7:0] name_char_in, // own device-name character
  input wire [15:0] handler_len_in, // handler length in bytes
  input wire disk_emul_in, // imitate first disk unit
  input wire img_wr_in, // image load strobe
  input wire [8:0] img_addr_in, // image load address
  input wire [7:0] img_data_in, // image load data
  output reg [7:0] tx_byte_out, // byte to send
  output reg tx_valid_out, // byte valid
  input wire tx_ready_in, // sender ready
  output reg busy_out, // answering a command
  output reg polled_out, // repeatable poll answered
  output reg legacy_done_out // legacy poll answered
);
  // ========================================================
  // states
  localparam S_CMD = 3'd0; // gather frame
  localparam S_ACK = 3'd1; // queue ack
  localparam S_CPL = 3'd2; // queue complete
  localparam S_DATA = 3'd3; // queue payload
  localparam S_SUM = 3'd4; // queue checksum
  localparam S_NAK = 3'd5; // queue refusal
  // payload sources
  localparam P_DESC = 2'd0; // transfer descriptor
  localparam P_POLL = 2'd1; // poll answer
  localparam P_IMG = 2'd2; // image block

  reg [7:0] img_mem [0:`PPR_IMG_DEPTH-1]; // handler record stream
  reg [7:0] frm_reg [0:3]; // frame bytes
  reg [2:0] idx_reg; // frame byte index
  reg [7:0] csum_reg; // running receive sum
  reg [2:0] state_reg; // sequencer state
  reg [1:0] src_reg; // payload source
  reg [7:0] pos_reg; // payload position
  reg [7:0] len_reg; // payload length
  reg [7:0] txsum_reg; // running transmit sum
  reg [8:0] base_reg; // image block base
  reg [4:0] retry_reg; // consecutive main polls
  reg [3:0] stat_cnt_reg; // consecutive disk status requests
  reg [7:0] f_data; // fifo fill data
  reg f_valid; // fifo fill valid
  wire f_ready; // fifo room
  wire [7:0] q_data; // fifo head
  wire q_valid; // fifo head valid
  reg [7:0] pay_byte; // current payload byte
  wire [8:0] sum_w; // receive sum with carry
  wire [8:0] tsum_w; // transmit sum with carry
  wire [15:0] even_len; // length forced even

  // end-around carry: fold carry back into low byte
  assign sum_w = {1'b0, csum_reg} + {1'b0, rx_byte_in}; // R20
  assign tsum_w = {1'b0, txsum_reg} + {1'b0, f_data}; // R20
  assign even_len = {handler_len_in[15:1], 1'b0}; // R8

  // image loading port; content holds type/length records
  always @(posedge sys_clk_in) begin
    if (img_wr_in) begin
      img_mem[img_addr_in] <= img_data_in; // R14 R15 R16 R17 R18
    end
  end

  // ========================================================
  // payload byte select
  always @* begin
    pay_byte = 8'h00;
    case (src_reg)
      P_DESC: begin
        // descriptor: target id, download cmd, then zeros
        if (pos_reg == 8'h00) begin
          pay_byte = dev_id_in;
        end else if (pos_reg == 8'h01) begin
          pay_byte = `PPR_CMD_DOWNLOAD;
        end
      end
      P_POLL: begin
        case (pos_reg[1:0]) // R7
          2'd0: pay_byte = even_len[7:0];
          2'd1: pay_byte = even_len[15:8];
          2'd2: pay_byte = dev_id_in;
          default: pay_byte = version_in;
        endcase
      end
      P_IMG: begin
        pay_byte = img_mem[base_reg + {1'b0, pos_reg}]; // R12
      end
      default: pay_byte = 8'h00;
    endcase
  end

  // ========================================================
  // byte fifo toward the sender
  ppr_fifo #(.WIDTH(8), .DEPTH(`PPR_FIFO_DEPTH), .AW(3)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .wr_data_in(f_data),
    .wr_valid_in(f_valid),
    .wr_ready_out(f_ready),
    .rd_data_out(q_data),
    .rd_valid_out(q_valid),
    .rd_ready_in(tx_ready_in || !tx_valid_out)
  );

  // fifo fill data by state; every answer state pushes one byte per cycle while the fifo has room
  always @* begin
    f_valid = (state_reg != S_CMD) && (state_reg <= S_NAK);
    case (state_reg)
      S_ACK: f_data = `PPR_ACK; // R19
      S_NAK: f_data = `PPR_NAK; // R19 R13
      S_CPL: f_data = `PPR_COMPLETE;
      S_DATA: f_data = pay_byte;
      S_SUM: f_data = txsum_reg;
      default: f_data = 8'h00;
    endcase
  end

  // output register stage: stalls while sender is busy
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_byte_out <= 8'h00;
      tx_valid_out <= 1'b0;
    end else if (tx_ready_in || !tx_valid_out) begin
      tx_byte_out <= q_data;
      tx_valid_out <= q_valid;
    end
  end

  // ========================================================
  // frame decode and answer sequencer
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_reg <= 3'd0;
      csum_reg <= 8'h00;
      state_reg <= S_CMD;
      src_reg <= P_DESC;
      pos_reg <= 8'h00;
      len_reg <= 8'h00;
      txsum_reg <= 8'h00;
      base_reg <= 9'd0;
      retry_reg <= 5'd0; // R21
      stat_cnt_reg <= 4'd0;
      busy_out <= 1'b0;
      polled_out <= 1'b0; // R21
      legacy_done_out <= 1'b0; // R21
      frm_reg[0] <= 8'h00;
      frm_reg[1] <= 8'h00;
      frm_reg[2] <= 8'h00;
      frm_reg[3] <= 8'h00;
    end else begin
      case (state_reg)
        S_CMD: begin
          busy_out <= 1'b0;
          // frame restarts whenever the command line is released
          if (!cmd_line_in) begin
            idx_reg <= 3'd0;
            csum_reg <= 8'h00;
          end else if (rx_valid_in && idx_reg < 3'd4) begin
            frm_reg[idx_reg[1:0]] <= rx_byte_in;
            csum_reg <= sum_w[7:0] + {7'd0, sum_w[8]}; // R20
            idx_reg <= idx_reg + 3'd1;
          end else if (rx_valid_in && idx_reg == 3'd4) begin
            idx_reg <= 3'd5;
            // bad sum: frame dropped silently
            if (rx_byte_in == csum_reg) begin // R20
              // poll decoded on command code alone, any address
              if (frm_reg[1] == `PPR_CMD_POLL) begin // R4
                if (frm_reg[2] == `PPR_SUB_RESET &&
                    frm_reg[3] == `PPR_SUB_RESET) begin
                  polled_out <= 1'b0; // R5 R9
                  retry_reg <= 5'd0; // R5
                end else if (frm_reg[2] == `PPR_SUB_NULL &&
                             frm_reg[3] == `PPR_SUB_NULL) begin
                  retry_reg <= 5'd0; // R10
                end else if (frm_reg[2] == `PPR_SUB_MAIN &&
                             frm_reg[3] == `PPR_SUB_MAIN) begin
                  // count saturates at the last slot
                  if (retry_reg != `PPR_RETRY_SLOTS) begin
                    retry_reg <= retry_reg + 5'd1; // R6
                  end
                  if (!polled_out &&
                      retry_reg + 5'd1 == retry_slot_in) begin // R6 R9
                    polled_out <= 1'b1; // R9
                    src_reg <= P_POLL;
                    len_reg <= `PPR_POLL_LEN;
                    state_reg <= S_ACK;
                    busy_out <= 1'b1;
                  end
                end else begin
                  retry_reg <= 5'd0; // R21
                  // named poll: name char and unit number
                  if (frm_reg[2] == name_char_in &&
                      frm_reg[3] <= 8'h01) begin // R11
                    src_reg <= P_POLL;
                    len_reg <= `PPR_POLL_LEN;
                    state_reg <= S_ACK;
                    busy_out <= 1'b1;
                  end
                end
              end else begin
                retry_reg <= 5'd0; // R21
                if (frm_reg[1] == `PPR_CMD_LEGACY &&
                    frm_reg[0] == dev_id_in) begin
                  // parameter bytes ignored
                  busy_out <= 1'b1;
                  if (legacy_done_out) begin
                    state_reg <= S_NAK; // R2
                  end else begin
                    legacy_done_out <= 1'b1; // R2
                    src_reg <= P_DESC; // R1
                    len_reg <= `PPR_DESC_LEN; // R1
                    state_reg <= S_ACK;
                  end
                end else if (frm_reg[1] == `PPR_CMD_DOWNLOAD &&
                             frm_reg[0] == dev_id_in) begin
                  busy_out <= 1'b1;
                  if (frm_reg[2] >= `PPR_IMG_BLOCKS) begin
                    state_reg <= S_NAK; // R13
                  end else begin
                    base_reg <= {frm_reg[2][1:0], 7'd0}; // R12
                    src_reg <= P_IMG;
                    len_reg <= `PPR_BLOCK_LEN; // R12
                    state_reg <= S_ACK;
                  end
                end else if (disk_emul_in &&
                             frm_reg[0] == `PPR_ADDR_DISK1) begin
                  // hold off so a real drive answers first
                  if (frm_reg[1] == `PPR_CMD_STATUS) begin
                    if (stat_cnt_reg != 4'hF) begin
                      stat_cnt_reg <= stat_cnt_reg + 4'd1; // R3
                    end
                  end else if (frm_reg[1] == `PPR_CMD_READ &&
                               frm_reg[2] == 8'h01 &&
                               frm_reg[3] == 8'h00 &&
                               stat_cnt_reg >= `PPR_STATUS_HOLD) begin
                    base_reg <= 9'd0; // R3
                    src_reg <= P_IMG;
                    len_reg <= `PPR_BLOCK_LEN;
                    state_reg <= S_ACK;
                    busy_out <= 1'b1;
                  end else begin
                    stat_cnt_reg <= 4'd0;
                  end
                end
              end
            end
          end
        end
        S_ACK: begin
          if (f_ready) begin
            state_reg <= S_CPL;
          end
        end
        S_CPL: begin
          if (f_ready) begin
            pos_reg <= 8'h00;
            txsum_reg <= 8'h00;
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          if (f_ready) begin
            txsum_reg <= tsum_w[7:0] + {7'd0, tsum_w[8]}; // R20
            pos_reg <= pos_reg + 8'h01;
            if (pos_reg + 8'h01 == len_reg) begin
              state_reg <= S_SUM;
            end
          end
        end
        // last byte of an answer or a lone refusal
        S_SUM, S_NAK: begin
          if (f_ready) begin
            state_reg <= S_CMD;
          end
        end
        default: state_reg <= S_CMD;
      endcase
    end
  end
endmodule

// >>> test/ppr_chk.sv
// checker for the poll responder, watching only its ports
// assumes frames are bounded by cmd_line_in as the host model drives them
module ppr_chk (
  input logic sys_clk_in, // clock
  input logic nrst_in, // reset, low
  input logic [7:0] rx_byte_in, // rx byte
  input logic rx_valid_in, // rx strobe
  input logic cmd_line_in, // frame line
  input logic [7:0] dev_id_in, // own id
  input logic [7:0] tx_byte_out, // tx byte
  input logic tx_valid_out, // tx valid
  input logic tx_ready_in, // tx ready
  input logic busy_out, // answering
  input logic polled_out, // sticky flag
  input logic legacy_done_out // legacy flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // frame capture helper
  logic [7:0] fr_reg [0:3]; // first four bytes
  logic [2:0] idx_reg; // byte index, 5 = extras
  logic [7:0] sum_reg; // running sum
  logic [8:0] add; // sum plus byte
  logic take, good, bad, is_leg, is_poll;
  assign take = rx_valid_in && cmd_line_in;
  assign add = {1'b0, sum_reg} + {1'b0, rx_byte_in};
  assign good = take && idx_reg == 3'd4 && rx_byte_in == sum_reg && !busy_out;
  assign bad = take && idx_reg == 3'd4 && rx_byte_in != sum_reg && !busy_out;
  assign is_leg = fr_reg[1] == 8'h3F && fr_reg[0] == dev_id_in;
  assign is_poll = fr_reg[1] == 8'h40;
  // index restarts whenever the line drops
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_reg <= 3'd0;
      sum_reg <= 8'h00;
    end else if (!cmd_line_in) begin
      idx_reg <= 3'd0;
      sum_reg <= 8'h00;
    end else if (take && idx_reg < 3'd4) begin
      idx_reg <= idx_reg + 3'd1;
      sum_reg <= add[7:0] + {7'h00, add[8]}; // carry folded back
      fr_reg[idx_reg[1:0]] <= rx_byte_in;
    end else if (take) begin
      idx_reg <= 3'd5; // extras must not look like a sum
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_TX_HOLD: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("tx byte changed before taken");
  AST_LEG_ANS: assert property (
    good && is_leg && !legacy_done_out |->
    ##[1:8] (tx_valid_out && tx_byte_out == 8'h41))
    else $error("legacy poll not acknowledged");
  AST_LEG_REFUSE: assert property (
    good && is_leg && legacy_done_out |->
    ##[1:8] (tx_valid_out && tx_byte_out == 8'h4E))
    else $error("repeated legacy poll not refused");
  AST_LEG_STICKY: assert property (
    legacy_done_out |=> legacy_done_out)
    else $error("legacy flag cleared");
  AST_RST_QUIET: assert property (
    good && is_poll && fr_reg[2] == 8'h4F && fr_reg[3] == 8'h4F |=>
    (!busy_out) [*6] ##1 !polled_out)
    else $error("poll reset answered or flag kept");
  AST_NULL_QUIET: assert property (
    good && is_poll && fr_reg[2] == 8'h4E && fr_reg[3] == 8'h4E |=>
    (!busy_out) [*8])
    else $error("null poll answered");
  AST_SUM_QUIET: assert property (
    bad |=> (!busy_out) [*8])
    else $error("frame with bad sum answered");
  AST_POLL_ONCE: assert property (
    good && is_poll && fr_reg[2] == 8'h00 && fr_reg[3] == 8'h00 &&
    polled_out |=> (!busy_out) [*8])
    else $error("main poll answered twice");
  AST_POLL_FALL: assert property (
    $fell(polled_out) |-> fr_reg[2] == 8'h4F && fr_reg[3] == 8'h4F)
    else $error("poll flag cleared without reset");
  AST_FIRST_BYTE: assert property (
    $rose(busy_out) |->
    ##[0:8] (tx_valid_out && (tx_byte_out == 8'h41 || tx_byte_out == 8'h4E)))
    else $error("answer did not open with ack or nak");
  cover property (good && is_leg);
  cover property ($rose(polled_out));
  cover property (bad);
endmodule

// >>> test/ppr_host.sv
// host model: sends five-byte command frames and gathers the answer
// assumes the responder holds busy_in high while an answer is pending
module ppr_host (
  input logic sys_clk_in, // clock
  output logic [7:0] rx_byte_out, // frame byte
  output logic rx_valid_out, // byte strobe
  output logic cmd_line_out, // frame line
  output logic tx_ready_out, // sink ready
  input logic [7:0] tx_byte_in, // answer byte
  input logic tx_valid_in, // answer valid
  input logic busy_in // answer pending
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$]; // answer bytes
  logic slow = 1'b0; // stall every other cycle
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    cmd_line_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // ==========================================
  // one frame out, then gather until quiet
  task automatic send(input logic [31:0] fw, input bit bad);
    logic [7:0] b[5];
    logic [8:0] s;
    int quiet;
    s = 9'h000;
    for (int i = 0; i < 4; i++) begin
      b[i] = fw[31-8*i -: 8];
      s = {1'b0, s[7:0]} + {1'b0, b[i]} + {8'h00, s[8]};
    end
    b[4] = s[7:0] + {7'h00, s[8]} ^ {7'h00, bad};
    @(posedge sys_clk_in);
    #1 cmd_line_out = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rx_byte_out = b[i];
      rx_valid_out = 1'b1;
      @(posedge sys_clk_in);
      #1;
    end
    rx_valid_out = 1'b0;
    rx_byte_out = ~b[4]; // released line shows no stale byte
    cmd_line_out = 1'b0;
    got.delete();
    quiet = 0;
    // bounded: a hung answer ends the gather, the count check reports it
    for (int n = 0; n < 1200 && quiet < 40; n++) begin
      @(posedge sys_clk_in);
      if (tx_valid_in && tx_ready_out) got.push_back(tx_byte_in);
      quiet = (busy_in || tx_valid_in) ? 0 : quiet + 1;
      #1 tx_ready_out = !slow || !tx_ready_out;
    end
  endtask
endmodule

// >>> test/test_peripheral_poll_responder.sv
// bench: table of frames through the host model, then a reset check
// assumes the host model gathers each answer into its byte queue
module test_peripheral_poll_responder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] fw; bit bad; int kind; int blk;} ppr_row_t;
  localparam logic [15:0] LEN = 16'h0101; // odd on purpose
  logic sys_clk_in, nrst_in, img_wr_in, disk_emul_in;
  logic [8:0] img_addr_in;
  logic [7:0] img_data_in, rx_byte_in, tx_byte_out;
  logic rx_valid_in, cmd_line_in, tx_valid_out, tx_ready_in;
  logic busy_out, polled_out, legacy_done_out;
  logic [7:0] version_in = 8'h13; // version byte the responder reports
  logic [7:0] name_char_in = 8'h48; // own device-name character
  logic [4:0] retry_slot_in = 5'h03; // own retry slot
  logic [7:0] img [0:511]; // image copy
  logic [7:0] exp_q[$]; // expected answer
  int bad_count = 0;
  int checked = 0;
  // record stream head: data, high-byte relocation pair, end record
  logic [7:0] hdr [14] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hAA, 8'hBB,
    8'h08, 8'h02, 8'h01, 8'hCC, 8'h0B, 8'h02, 8'h00, 8'h00};
  // kind: 0 silent, 1 nak, 2 descriptor, 3 poll, 4 block
  ppr_row_t rows [32] = '{'{32'h5A3F1234, 1, 0, 0},
    '{32'h5A3F1234, 0, 2, 0}, '{32'h5A3F0000, 0, 1, 0},
    '{32'h4F404F4F, 0, 0, 0}, '{32'h4F400000, 0, 0, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h4F400000, 0, 3, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h4F404F4F, 0, 0, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h4F404E4E, 0, 0, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h4F400000, 0, 0, 0},
    '{32'h4F400000, 0, 3, 0}, '{32'h4F404F4F, 0, 0, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h5A260000, 0, 4, 0},
    '{32'h4F400000, 0, 0, 0}, '{32'h4F400000, 0, 0, 0},
    '{32'h4F400000, 0, 3, 0}, '{32'h5A260300, 0, 4, 3},
    '{32'h5A260400, 0, 1, 0}, '{32'h5B260000, 0, 0, 0},
    '{32'h4F404801, 0, 3, 0}, '{32'h4F404901, 0, 0, 0},
    '{32'h7A404800, 0, 3, 0}, '{32'h5A3F0000, 0, 1, 0},
    '{32'h31520100, 0, 0, 0}, '{32'h31530000, 0, 0, 0},
    '{32'h31530000, 0, 0, 0}, '{32'h31530000, 0, 0, 0},
    '{32'h31520100, 0, 4, 0}};
  ppr_responder ppr_responder_i (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in),
    .cmd_line_in(cmd_line_in), .dev_id_in(8'h5A), .version_in(version_in),
    .retry_slot_in(retry_slot_in), .name_char_in(name_char_in),
    .handler_len_in(LEN),
    .disk_emul_in(disk_emul_in), .img_wr_in(img_wr_in),
    .img_addr_in(img_addr_in), .img_data_in(img_data_in),
    .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .busy_out(busy_out),
    .polled_out(polled_out), .legacy_done_out(legacy_done_out));
  ppr_host ppr_host_i (.sys_clk_in(sys_clk_in), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in), .cmd_line_out(cmd_line_in),
    .tx_ready_out(tx_ready_in), .tx_byte_in(tx_byte_out),
    .tx_valid_in(tx_valid_out), .busy_in(busy_out));
  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected answer: nothing, a lone nak, or ack, complete, payload, folded sum
  task automatic build(input int kind, input int blk);
    logic [7:0] p[$];
    logic [8:0] s;
    exp_q.delete();
    if (kind == 1) exp_q.push_back(8'h4E);
    if (kind < 2 || kind > 4) return;
    exp_q.push_back(8'h41);
    exp_q.push_back(8'h43);
    if (kind == 2) p = {8'h5A, 8'h26};
    if (kind == 2) repeat (10) p.push_back(8'h00);
    if (kind == 3) p = {LEN[7:0] & 8'hFE, LEN[15:8], 8'h5A, version_in};
    if (kind == 4) for (int i = 0; i < 128; i++) p.push_back(img[blk*128+i]);
    s = 9'h000;
    foreach (p[i]) s = {1'b0, s[7:0]} + {1'b0, p[i]} + {8'h00, s[8]};
    exp_q = {exp_q, p};
    exp_q.push_back(s[7:0] + {7'h00, s[8]});
  endtask
  task automatic run_row(input ppr_row_t rw);
    ppr_host_i.send(rw.fw, rw.bad);
    build(rw.kind, rw.blk);
    check("count", 8'(ppr_host_i.got.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) if (i < ppr_host_i.got.size()) begin
      check("byte", ppr_host_i.got[i], exp_q[i]);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #1_000_000;
    bad_count++;
    complete_run();
  end
  initial begin
    nrst_in = 1'b0;
    img_wr_in = 1'b0;
    img_addr_in = 9'h000;
    img_data_in = 8'h00;
    disk_emul_in = 1'b1;
    for (int a = 0; a < 512; a++) img[a] = 8'(a) ^ {a[8], 7'h00} ^ 8'hA5;
    for (int a = 0; a < 14; a++) img[a] = hdr[a];
    repeat (10) @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    for (int a = 0; a < 512; a++) begin
      img_wr_in = 1'b1;
      img_addr_in = 9'(a);
      img_data_in = img[a];
      @(posedge sys_clk_in);
      #1;
    end
    img_wr_in = 1'b0;
    for (int r = 0; r < 32; r++) begin
      ppr_host_i.slow = (r >= 16); // stalls back the fifo up
      run_row(rows[r]);
    end
    // leave the retry count at one so the reset has something to clear
    run_row('{32'h4F400000, 0, 0, 0});
    // reset in mid-run clears flags and the retry count
    ppr_host_i.slow = 1'b0;
    nrst_in = 1'b0;
    retry_slot_in = 5'h02; // a second slot and version after power-up
    version_in = 8'hC7;
    #40;
    check("polled", {7'h00, polled_out}, 8'h00);
    check("legacy", {7'h00, legacy_done_out}, 8'h00);
    check("busy", {7'h00, busy_out}, 8'h00);
    @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    run_row('{32'h4F400000, 0, 0, 0});
    run_row('{32'h4F400000, 0, 3, 0});
    run_row('{32'h4F400000, 0, 0, 0});
    run_row('{32'h5A3F0000, 0, 2, 0});
    complete_run();
  end
endmodule
bind ppr_responder ppr_chk ppr_chk_i (.sys_clk_in, .nrst_in, .rx_byte_in,
  .rx_valid_in, .cmd_line_in, .dev_id_in, .tx_byte_out, .tx_valid_out,
  .tx_ready_in, .busy_out, .polled_out, .legacy_done_out);
